// ### design/udc_usb_control.v
// USB function control registers and RAM to endpoint copy engine front end
// What this block does
// - Direction bit: one IN, zero OUT, control ignored
// - Type field selects control, iso, bulk, interrupt
// - Endpoint reset clears pointers, toggle, then bit
// - Resume flag high during wake-up signalling
// - Wake-up only when software enables it
// - Bus reset clears configured flag
// - Bus reset clears address and addressed flag
// - Eleven-bit frame number from SOF packets
// - Frame end set at SOF end, cleared next
// - Frame error follows last frame field check
// - Registers inaccessible while USB module disabled
// - N byte copy ends within N+2 cycles
// - Launch stalls CPU until copy ends
// - Copy control holds select, error, direction, run
// - Direction zero endpoint to RAM, one reverse
// - Hardware clears run bit at completion
// - Bad window or count sets error, no copy
// - Address register ends at last plus one
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "udc_map.vh"
module udc_usb_control #(
  parameter RESUME_CYCLES = `UDC_RESUME_CYCLES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        srst,
  // Avalon-MM slave
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire [1:0]  avs_response,
  // USB module enable and CPU stall
  input  wire        usb_enable,
  output wire        cpu_stall,
  // USB protocol engine events
  input  wire        bus_reset,
  input  wire        sof_start,
  input  wire        sof_end,
  input  wire        sof_crc_bad,
  input  wire [10:0] sof_frame,
  input  wire        host_suspended,
  // Resume drive and endpoint control toward the engine
  output wire        resume_drive,
  output reg  [7:0]  ep_enable_q,
  output reg  [7:0]  ep_dir_in_q,
  output reg  [15:0] ep_type_q,
  output reg  [7:0]  ep_flush_q,
  output reg  [7:0]  ep_toggle_clr_q,
  // System RAM port
  output wire        ram_we,
  output wire        ram_re,
  output wire [11:0] ram_addr,
  output wire [7:0]  ram_wdata,
  input  wire [7:0]  ram_rdata,
  // Endpoint buffer port
  output wire        ep_we,
  output wire        ep_re,
  output wire [2:0]  ep_num,
  output wire [6:0]  ep_ptr,
  output wire [7:0]  ep_wdata,
  input  wire [7:0]  ep_rdata
);
  // ==================== State
  reg [2:0]  ep_sel_q;
  reg [7:0]  ep_reset_q;
  reg        wake_en_q;
  reg        wake_req_q;
  reg        configured_q;
  reg        addressed_q;
  reg [6:0]  func_addr_q;
  reg [10:0] frame_q;
  reg        frame_end_q;
  reg        frame_err_q;
  reg        resume_q;
  reg [19:0] resume_cnt_q;
  reg [2:0]  cp_ep_q;
  reg        cp_err_q;
  reg        cp_dir_q;
  reg        cp_run_q;
  reg [11:0] cp_addr_q;
  reg [6:0]  cp_count_q;
  reg        resp_q;
  reg        ack_q;

  wire [7:0] idx = avs_address[9:2];
  wire [7:0] wb  = avs_writedata[7:0];
  wire       wr  = avs_write & ack_q & avs_byteenable[0] & usb_enable;
  wire       eng_busy;
  wire       eng_done;
  wire [11:0] eng_next;
  wire       launch;

  // Endpoint size by selector
  function [7:0] ep_size;
    input [2:0] sel;
    begin
      if (sel == 3'd0)
        ep_size = `UDC_EP_SIZE_EP0;
      else if (sel[2])
        ep_size = `UDC_EP_SIZE_SMALL;
      else
        ep_size = `UDC_EP_SIZE_BIG;
    end
  endfunction

  // Launch check against window, count and endpoint size
  wire [12:0] cp_end   = {1'b0, cp_addr_q} + {6'h00, cp_count_q} - 13'h0001;
  wire        cp_bad   = (cp_addr_q < `UDC_RAM_LOW) | (cp_addr_q > `UDC_RAM_HIGH) |
                         (cp_end > {1'b0, `UDC_RAM_HIGH}) | (cp_count_q == 7'h00) |
                         ({1'b0, cp_count_q} > ep_size(wb[6:4])) | (wb[6:4] > 3'd4);
  wire        run_wr   = wr & (idx == `UDC_IDX_COPY_CTRL) & wb[`UDC_CC_RUN] & ~cp_run_q;
  assign launch = run_wr & ~cp_bad & ~eng_busy;

  // ==================== Avalon handshake: one wait state, then answer
  // Writes land on the answer edge only, so a held launch never repeats
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_response    = resp_q ? 2'b11 : 2'b00;
  assign cpu_stall       = cp_run_q | eng_busy;
  assign resume_drive    = resume_q;

  always @(posedge core_clk) begin
    if (srst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q & ~cpu_stall;
  end

  // Read data mux registered on the wait cycle
  always @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
      resp_q       <= 1'b0;
    end else if ((avs_read | avs_write) & ~ack_q) begin
      resp_q       <= ~usb_enable;
      avs_readdata <= 32'h0000_0000;
      if (usb_enable & avs_read) begin
        case (idx)
          `UDC_IDX_EP_SEL:      avs_readdata[2:0] <= ep_sel_q;
          `UDC_IDX_EP_FUNC:     avs_readdata[7:0] <= {ep_enable_q[ep_sel_q], 4'h0, ep_dir_in_q[ep_sel_q],
                                                      ep_type_q[2*ep_sel_q +: 2]};
          `UDC_IDX_EP_RESET:    avs_readdata[7:0] <= ep_reset_q;
          `UDC_IDX_GLOBAL:      avs_readdata[3:0] <= {resume_q, wake_en_q, configured_q, addressed_q};
          `UDC_IDX_FUNC_ADDR:   avs_readdata[6:0] <= func_addr_q;
          `UDC_IDX_FRAME_LO:    avs_readdata[7:0] <= frame_q[7:0];
          `UDC_IDX_FRAME_HI:    avs_readdata[4:0] <= {frame_end_q, frame_err_q, frame_q[10:8]};
          `UDC_IDX_COPY_CTRL:   avs_readdata[7:0] <= {1'b0, cp_ep_q, 1'b0, cp_err_q, cp_dir_q, cp_run_q};
          `UDC_IDX_COPY_ADDR_L: avs_readdata[7:0] <= cp_addr_q[7:0];
          `UDC_IDX_COPY_ADDR_H: avs_readdata[3:0] <= cp_addr_q[11:8];
          `UDC_IDX_COPY_COUNT:  avs_readdata[6:0] <= cp_count_q;
          default:              avs_readdata      <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==================== Endpoint configuration
  always @(posedge core_clk) begin
    if (srst) begin
      ep_sel_q    <= 3'b000;
      ep_enable_q <= `UDC_RST_BYTE;
      ep_dir_in_q <= `UDC_RST_BYTE;
      ep_type_q   <= 16'h0000;
    end else begin
      if (bus_reset)
        ep_enable_q[0] <= 1'b1;
      if (wr & (idx == `UDC_IDX_EP_SEL))
        ep_sel_q <= wb[2:0];
      if (wr & (idx == `UDC_IDX_EP_FUNC)) begin
        ep_enable_q[ep_sel_q]        <= wb[`UDC_FC_ENABLE];
        // Direction forced to zero (OUT) for control endpoints
        ep_dir_in_q[ep_sel_q]        <= wb[`UDC_FC_DIR] & (wb[1:0] != `UDC_TT_CONTROL);
        ep_type_q[2*ep_sel_q +: 2]   <= wb[1:0];
      end
    end
  end

  // ==================== Endpoint reset: one-cycle pulse then self clear
  always @(posedge core_clk) begin
    if (srst) begin
      ep_reset_q      <= `UDC_RST_BYTE;
      ep_flush_q      <= `UDC_RST_BYTE;
      ep_toggle_clr_q <= `UDC_RST_BYTE;
    end else begin
      ep_flush_q      <= ep_reset_q;
      ep_toggle_clr_q <= ep_reset_q;
      if (wr & (idx == `UDC_IDX_EP_RESET))
        ep_reset_q <= wb & ~ep_reset_q;
      else
        ep_reset_q <= 8'h00;
    end
  end

  // ==================== Global state and address
  always @(posedge core_clk) begin
    if (srst) begin
      wake_en_q    <= 1'b0;
      configured_q <= 1'b0;
      addressed_q  <= 1'b0;
      func_addr_q  <= 7'h00;
    end else begin
      if (wr & (idx == `UDC_IDX_GLOBAL)) begin
        wake_en_q    <= wb[`UDC_GS_WAKE_EN];
        configured_q <= wb[`UDC_GS_CONFIGURED];
        addressed_q  <= wb[`UDC_GS_ADDRESSED];
      end
      if (wr & (idx == `UDC_IDX_FUNC_ADDR))
        func_addr_q <= wb[6:0];
      if (bus_reset) begin
        configured_q <= 1'b0;
        addressed_q  <= 1'b0;
        func_addr_q  <= 7'h00;
      end
    end
  end

  // ==================== Remote wake-up resume timer
  always @(posedge core_clk) begin
    if (srst) begin
      resume_q     <= 1'b0;
      resume_cnt_q <= 20'h0_0000;
      wake_req_q   <= 1'b0;
    end else begin
      wake_req_q <= host_suspended & wake_en_q;
      if (~resume_q & wake_req_q & wake_en_q) begin
        resume_q     <= 1'b1;
        resume_cnt_q <= RESUME_CYCLES[19:0] - 20'h0_0001;
      end else if (resume_q) begin
        if (resume_cnt_q == 20'h0_0000)
          resume_q <= 1'b0;
        else
          resume_cnt_q <= resume_cnt_q - 20'h0_0001;
      end
    end
  end

  // ==================== Frame number capture
  always @(posedge core_clk) begin
    if (srst) begin
      frame_q     <= 11'h000;
      frame_end_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      if (sof_start)
        frame_end_q <= 1'b0;
      if (sof_end) begin
        frame_end_q <= 1'b1;
        frame_err_q <= sof_crc_bad;
        if (~sof_crc_bad)
          frame_q <= sof_frame;
      end
    end
  end

  // ==================== Copy engine registers
  always @(posedge core_clk) begin
    if (srst) begin
      cp_ep_q    <= 3'b000;
      cp_err_q   <= 1'b0;
      cp_dir_q   <= 1'b0;
      cp_run_q   <= 1'b0;
      cp_addr_q  <= `UDC_RST_COPY_ADDR;
      cp_count_q <= 7'h00;
    end else begin
      if (wr & (idx == `UDC_IDX_COPY_CTRL)) begin
        cp_ep_q  <= wb[6:4];
        cp_dir_q <= wb[`UDC_CC_DIR];
        if (~wb[`UDC_CC_ERR])
          cp_err_q <= 1'b0;
      end
      if (wr & (idx == `UDC_IDX_COPY_ADDR_L))
        cp_addr_q[7:0] <= wb;
      if (wr & (idx == `UDC_IDX_COPY_ADDR_H))
        cp_addr_q[11:8] <= wb[3:0];
      if (wr & (idx == `UDC_IDX_COPY_COUNT))
        cp_count_q <= wb[6:0];
      if (run_wr)
        cp_err_q <= cp_bad;
      if (launch)
        cp_run_q <= 1'b1;
      if (eng_done) begin
        cp_run_q  <= 1'b0;
        cp_addr_q <= eng_next;
      end
    end
  end

  udc_copy_engine #(
    .AW(12)
  ) u_copy (
    .core_clk    (core_clk),
    .srst        (srst),
    .start       (launch),
    .dir_to_ep   (wb[`UDC_CC_DIR]),
    .ep_sel      (wb[6:4]),
    .base_addr   (cp_addr_q),
    .byte_count  (cp_count_q),
    .busy        (eng_busy),
    .next_addr_q (eng_next),
    .done_q      (eng_done),
    .ram_we_q    (ram_we),
    .ram_re_q    (ram_re),
    .ram_addr_q  (ram_addr),
    .ram_wdata_q (ram_wdata),
    .ram_rdata   (ram_rdata),
    .ep_we_q     (ep_we),
    .ep_re_q     (ep_re),
    .ep_num_q    (ep_num),
    .ep_ptr_q    (ep_ptr),
    .ep_wdata_q  (ep_wdata),
    .ep_rdata    (ep_rdata)
  );
endmodule // udc_usb_control

// ### design/udc_map.vh
// Register offsets, field positions, reset values and timing counts of the USB control block
`ifndef UDC_MAP_VH
`define UDC_MAP_VH
// ==================== Register word indices (byte address = 4 * index)
`define UDC_IDX_EP_SEL      8'hca
`define UDC_IDX_EP_FUNC     8'hcd
`define UDC_IDX_EP_RESET    8'he5
`define UDC_IDX_GLOBAL      8'he6
`define UDC_IDX_FUNC_ADDR   8'he7
`define UDC_IDX_FRAME_LO    8'he8
`define UDC_IDX_FRAME_HI    8'he9
`define UDC_IDX_COPY_CTRL   8'hea
`define UDC_IDX_COPY_ADDR_L 8'heb
`define UDC_IDX_COPY_ADDR_H 8'hec
`define UDC_IDX_COPY_COUNT  8'hed
// ==================== Field positions
`define UDC_FC_ENABLE       7
`define UDC_FC_DIR          2
`define UDC_GS_RESUME       3
`define UDC_GS_WAKE_EN      2
`define UDC_GS_CONFIGURED   1
`define UDC_GS_ADDRESSED    0
`define UDC_FH_END          4
`define UDC_FH_ERR          3
`define UDC_CC_ERR          2
`define UDC_CC_DIR          1
`define UDC_CC_RUN          0
// ==================== Transfer type encodings
`define UDC_TT_CONTROL      2'b00
`define UDC_TT_ISO          2'b01
`define UDC_TT_BULK         2'b10
`define UDC_TT_INTERRUPT    2'b11
// ==================== Reset values and copy window
`define UDC_RST_BYTE        8'h00
`define UDC_RST_COPY_ADDR   12'h100
`define UDC_RAM_LOW         12'h100
`define UDC_RAM_HIGH        12'h8ff
`define UDC_EP_SIZE_BIG     8'h80
`define UDC_EP_SIZE_EP0     8'h40
`define UDC_EP_SIZE_SMALL   8'h08
// ==================== Timing
`define UDC_CLK_HZ          40000000
`define UDC_RESUME_MS       13
`define UDC_RESUME_CYCLES   (`UDC_CLK_HZ / 1000 * `UDC_RESUME_MS)
`endif

// ### design/udc_copy_engine.v
// Copy engine moving bytes between system RAM and endpoint buffer RAM
`timescale 1ns/100ps
module udc_copy_engine #(
  parameter AW = 12
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          srst,
  // Launch
  input  wire          start,
  input  wire          dir_to_ep,
  input  wire [2:0]    ep_sel,
  input  wire [AW-1:0] base_addr,
  input  wire [6:0]    byte_count,
  // Status
  output wire          busy,
  output reg  [AW-1:0] next_addr_q,
  output reg           done_q,
  // System RAM port
  output reg           ram_we_q,
  output reg           ram_re_q,
  output reg  [AW-1:0] ram_addr_q,
  output reg  [7:0]    ram_wdata_q,
  input  wire [7:0]    ram_rdata,
  // Endpoint buffer port
  output reg           ep_we_q,
  output reg           ep_re_q,
  output reg  [2:0]    ep_num_q,
  output reg  [6:0]    ep_ptr_q,
  output reg  [7:0]    ep_wdata_q,
  input  wire [7:0]    ep_rdata
);
  localparam ST_IDLE = 3'b001;
  localparam ST_MOVE = 3'b010;
  localparam ST_LAST = 3'b100;

  reg [2:0]    state_q;
  reg [6:0]    left_q;
  reg          dir_q;
  reg [AW-1:0] base_q;
  reg [6:0]    idx_q;

  // RAM address of the byte read in this cycle, and the one after it
  wire [AW-1:0] byte_addr = base_q + {{(AW-7){1'b0}}, idx_q};
  wire [AW-1:0] byte_next = byte_addr + {{(AW-1){1'b0}}, 1'b1};

  // Busy from setup to the last write; launch strobe left out to avoid a loop
  assign busy = (state_q != ST_IDLE);

  // ====================
  // Setup cycle then one byte per cycle, address and pointer together
  always @(posedge core_clk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      left_q      <= 7'h00;
      dir_q       <= 1'b0;
      base_q      <= {AW{1'b0}};
      idx_q       <= 7'h00;
      next_addr_q <= {AW{1'b0}};
      done_q      <= 1'b0;
      ram_we_q    <= 1'b0;
      ram_re_q    <= 1'b0;
      ram_addr_q  <= {AW{1'b0}};
      ram_wdata_q <= 8'h00;
      ep_we_q     <= 1'b0;
      ep_re_q     <= 1'b0;
      ep_num_q    <= 3'b000;
      ep_ptr_q    <= 7'h00;
      ep_wdata_q  <= 8'h00;
    end else begin
      done_q   <= 1'b0;
      ram_we_q <= 1'b0;
      ep_we_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          ram_re_q <= 1'b0;
          ep_re_q  <= 1'b0;
          if (start) begin
            dir_q      <= dir_to_ep;
            left_q     <= byte_count;
            base_q     <= base_addr;
            idx_q      <= 7'h00;
            ram_addr_q <= base_addr;
            ep_num_q   <= ep_sel;
            ep_ptr_q   <= 7'h00;
            ram_re_q   <= dir_to_ep;
            ep_re_q    <= ~dir_to_ep;
            state_q    <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          // Write the byte read this cycle at its own index, read the next one
          if (dir_q) begin
            ep_we_q    <= 1'b1;
            ep_wdata_q <= ram_rdata;
            ep_ptr_q   <= idx_q;
          end else begin
            ram_we_q    <= 1'b1;
            ram_wdata_q <= ep_rdata;
            ram_addr_q  <= byte_addr;
          end
          next_addr_q <= byte_next;
          left_q      <= left_q - 7'h01;
          if (left_q == 7'h01) begin
            state_q  <= ST_LAST;
            ram_re_q <= 1'b0;
            ep_re_q  <= 1'b0;
          end else begin
            idx_q <= idx_q + 7'h01;
            if (dir_q)
              ram_addr_q <= byte_next;
            else
              ep_ptr_q <= idx_q + 7'h01;
          end
        end
        ST_LAST: begin
          done_q  <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // udc_copy_engine

// ### bench/udc_usb_control_asserts.sv
// Port checker for the USB control block
`timescale 1ns/100ps
module udc_usb_control_asserts #(
  parameter RESUME_CYCLES = 20
) (
  // Clock and reset
  input wire        core_clk,
  input wire        srst,
  // Register bus
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [1:0]  avs_response,
  input wire        usb_enable,
  input wire        cpu_stall,
  // Engine side
  input wire        resume_drive,
  input wire [7:0]  ep_flush_q,
  input wire [7:0]  ep_toggle_clr_q,
  input wire        ram_we,
  input wire        ram_re,
  input wire [11:0] ram_addr,
  input wire        ep_we
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ====================
  // Accepted transfer and resume run length
  wire       acc_w = (avs_read || avs_write) && !avs_waitrequest;
  reg [31:0] run_q;
  always @(posedge core_clk) begin
    if (srst || !resume_drive) run_q <= 32'h0000_0000;
    else run_q <= run_q + 32'h0000_0001;
  end
  // ====================
  // Properties
  a_stall_holds_wait: assert property (cpu_stall && (avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus answered during a copy");
  a_stall_ends_soon: assert property ($rose(cpu_stall) |-> ##[1:131] !cpu_stall)
    else $error("copy stall too long");
  a_disabled_resp: assert property (acc_w && !usb_enable |-> avs_response == 2'b11)
    else $error("disabled access not refused");
  a_disabled_data: assert property (acc_w && avs_read && !usb_enable |-> avs_readdata == 32'h0000_0000)
    else $error("disabled read returned data");
  a_enabled_resp: assert property (acc_w && usb_enable |-> avs_response == 2'b00)
    else $error("enabled access refused");
  a_resume_length: assert property ($fell(resume_drive) |-> run_q == RESUME_CYCLES)
    else $error("resume drive length wrong");
  a_flush_pulse: assert property (ep_flush_q != 8'h00 |=> ep_flush_q == 8'h00)
    else $error("flush not a pulse");
  a_flush_toggle: assert property (ep_flush_q == ep_toggle_clr_q)
    else $error("flush and toggle clear differ");
  a_one_side: assert property (!(ram_we && ep_we))
    else $error("both memories written");
  a_ram_window: assert property (ram_we || ram_re |-> ram_addr >= 12'h100 && ram_addr <= 12'h8ff)
    else $error("copy left the RAM window");
  a_byte_step: assert property ((ram_we || ram_re) && $past(ram_we || ram_re) |->
    ram_addr == $past(ram_addr) + 12'h001)
    else $error("RAM address did not step by one");
  // Main scenarios
  c_copy: cover property ($rose(cpu_stall));
  c_resume: cover property ($fell(resume_drive));
  c_flush: cover property (ep_flush_q != 8'h00);
endmodule // udc_usb_control_asserts
bind udc_usb_control udc_usb_control_asserts #(.RESUME_CYCLES(RESUME_CYCLES)) i_udc_usb_control_asserts (
  .core_clk(core_clk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .usb_enable(usb_enable), .cpu_stall(cpu_stall), .resume_drive(resume_drive), .ep_flush_q(ep_flush_q),
  .ep_toggle_clr_q(ep_toggle_clr_q), .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr), .ep_we(ep_we));

// ### bench/udc_mem_model.sv
// Model of system RAM and endpoint buffer RAM seen by the copy engine
`timescale 1ns/100ps
module udc_mem_model (
  // Clock
  input  wire        core_clk,
  // System RAM port
  input  wire        ram_we,
  input  wire        ram_re,
  input  wire [11:0] ram_addr,
  input  wire [7:0]  ram_wdata,
  output wire [7:0]  ram_rdata,
  // Endpoint buffer port
  input  wire        ep_we,
  input  wire        ep_re,
  input  wire [2:0]  ep_num,
  input  wire [6:0]  ep_ptr,
  input  wire [7:0]  ep_wdata,
  output wire [7:0]  ep_rdata
);
  reg [7:0] sys_mem [0:4095];
  reg [7:0] ep_mem  [0:1023];
  integer   i;
  // Known patterns so copied bytes can be traced
  initial begin
    for (i = 0; i < 4096; i = i + 1) sys_mem[i] = i[7:0] ^ 8'h3c;
    for (i = 0; i < 1024; i = i + 1) ep_mem[i] = i[7:0] ^ 8'h5a;
  end
  // Read in the cycle the address stands; inverted when not enabled
  assign ram_rdata = ram_re ? sys_mem[ram_addr] : ~sys_mem[ram_addr];
  assign ep_rdata  = ep_re ? ep_mem[{ep_num, ep_ptr}] : ~ep_mem[{ep_num, ep_ptr}];
  // Writes land on the edge that samples the enable
  always @(posedge core_clk) begin
    if (ram_we) sys_mem[ram_addr] <= ram_wdata;
    if (ep_we) ep_mem[{ep_num, ep_ptr}] <= ep_wdata;
  end
endmodule // udc_mem_model

// ### bench/testbench.sv
// Self-checking bench of the USB control block
`timescale 1ns/100ps
module testbench;
  reg         core_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, usb_enable = 1'b1;
  reg  [9:0]  avs_address = 10'h000;
  reg  [31:0] avs_writedata = 32'h0000_0000;
  reg         bus_reset = 1'b0, sof_start = 1'b0, sof_end = 1'b0, sof_crc_bad = 1'b0, host_suspended = 1'b0;
  reg  [10:0] sof_frame = 11'h000;
  wire [31:0] avs_readdata;
  wire [1:0]  avs_response;
  wire        avs_waitrequest, cpu_stall, resume_drive, ram_we, ram_re, ep_we, ep_re;
  wire [7:0]  ep_enable_q, ep_dir_in_q, ep_flush_q, ep_toggle_clr_q, ram_wdata, ram_rdata, ep_wdata, ep_rdata;
  wire [15:0] ep_type_q;
  wire [11:0] ram_addr;
  wire [2:0]  ep_num;
  wire [6:0]  ep_ptr;
  integer     err_total = 0, compares = 0, k, n;
  reg  [7:0]  rv;
  reg         flush_seen = 1'b0;
  always #12.5 core_clk = ~core_clk;
  udc_usb_control #(.RESUME_CYCLES(20)) i_udc_usb_control (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .usb_enable(usb_enable),
    .cpu_stall(cpu_stall), .bus_reset(bus_reset), .sof_start(sof_start), .sof_end(sof_end),
    .sof_crc_bad(sof_crc_bad), .sof_frame(sof_frame), .host_suspended(host_suspended),
    .resume_drive(resume_drive), .ep_enable_q(ep_enable_q), .ep_dir_in_q(ep_dir_in_q), .ep_type_q(ep_type_q),
    .ep_flush_q(ep_flush_q), .ep_toggle_clr_q(ep_toggle_clr_q), .ram_we(ram_we), .ram_re(ram_re),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ep_we(ep_we), .ep_re(ep_re),
    .ep_num(ep_num), .ep_ptr(ep_ptr), .ep_wdata(ep_wdata), .ep_rdata(ep_rdata));
  udc_mem_model i_udc_mem_model (
    .core_clk(core_clk), .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .ep_we(ep_we), .ep_re(ep_re), .ep_num(ep_num), .ep_ptr(ep_ptr),
    .ep_wdata(ep_wdata), .ep_rdata(ep_rdata));
  // Catch the one-cycle flush of endpoint 3
  always @(posedge core_clk) if (ep_flush_q[3] === 1'b1 && ep_toggle_clr_q[3] === 1'b1) flush_seen <= 1'b1;
  // ====================
  // Verdict and bus tasks
  task complete_run;
    begin
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task acc(input w, input [7:0] idx, input [7:0] wd);
    integer t;
    begin
      t = 0;
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h00_0000, wd};
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && t < 400) begin
        @(posedge core_clk);
        t = t + 1;
      end
      rv = avs_readdata[7:0];
      if (t >= 400) err_total = err_total + 1;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rc(input [7:0] idx, input [7:0] exp);
    begin
      acc(1'b0, idx, 8'h00);
      chk({24'h00_0000, rv}, {24'h00_0000, exp});
    end
  endtask
  // Start of frame, optionally with its end of packet
  task sof(input [10:0] f, input bad, input fin);
    begin
      sof_start <= 1'b1;
      @(posedge core_clk);
      sof_start <= 1'b0;
      sof_frame <= f;
      sof_crc_bad <= bad;
      @(posedge core_clk);
      sof_end <= fin;
      @(posedge core_clk);
      sof_end <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total = err_total + 1;
    complete_run;
  end
  // ====================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    for (k = 8'he5; k <= 8'hea; k = k + 1) rc(k[7:0], 8'h00);
    rc(8'heb, 8'h00);
    rc(8'hec, 8'h01);
    rc(8'h10, 8'h00);
    // Direction and type of endpoint 1
    acc(1'b1, 8'hca, 8'h01);
    for (k = 0; k < 4; k = k + 1) begin
      acc(1'b1, 8'hcd, 8'h84 | k[7:0]);
      rc(8'hcd, (k == 0) ? 8'h80 : (8'h84 | k[7:0]));
      chk({30'h0, ep_type_q[3:2]}, k);
      chk({31'h0, ep_dir_in_q[1]}, {31'h0, k != 0});
    end
    // Endpoint reset by clear, set, poll
    acc(1'b1, 8'he5, 8'h00);
    acc(1'b1, 8'he5, 8'h08);
    n = 0;
    rv = 8'hff;
    while (rv !== 8'h00 && n < 20) begin
      acc(1'b0, 8'he5, 8'h00);
      n = n + 1;
    end
    chk({24'h0, rv}, 32'h0000_0000);
    chk({31'h0, flush_seen}, 32'h0000_0001);
    // State flags and address against a bus reset
    acc(1'b1, 8'he6, 8'h07);
    acc(1'b1, 8'he7, 8'hff);
    rc(8'he6, 8'h07);
    rc(8'he7, 8'h7f);
    bus_reset <= 1'b1;
    @(posedge core_clk);
    bus_reset <= 1'b0;
    @(posedge core_clk);
    rc(8'he6, 8'h04);
    rc(8'he7, 8'h00);
    // Wake-up only when enabled
    acc(1'b1, 8'he6, 8'h00);
    host_suspended <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk({31'h0, resume_drive}, 32'h0000_0000);
    acc(1'b1, 8'he6, 8'h04);
    n = 0;
    while (resume_drive !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n = n + 1;
    end
    host_suspended <= 1'b0;
    rc(8'he6, 8'h0c);
    repeat (40) @(posedge core_clk);
    rc(8'he6, 8'h04);
    // Frame number, end and error flags
    sof(11'h5a3, 1'b0, 1'b1);
    rc(8'he9, 8'h15);
    rc(8'he8, 8'ha3);
    sof(11'h111, 1'b0, 1'b0);
    rc(8'he9, 8'h05);
    sof(11'h111, 1'b1, 1'b1);
    rc(8'he9, 8'h1d);
    rc(8'he8, 8'ha3);
    // Access refused while the module is off
    acc(1'b1, 8'he7, 8'h22);
    usb_enable <= 1'b0;
    acc(1'b1, 8'he7, 8'h11);
    rc(8'he7, 8'h00);
    chk({30'h0, avs_response}, 32'h0000_0003);
    usb_enable <= 1'b1;
    rc(8'he7, 8'h22);
    // Copy RAM to endpoint 1, then endpoint 2 to RAM
    acc(1'b1, 8'hed, 8'h04);
    acc(1'b1, 8'hea, 8'h13);
    rc(8'hea, 8'h12);
    rc(8'heb, 8'h04);
    for (k = 0; k < 4; k = k + 1) chk(i_udc_mem_model.ep_mem[128 + k], k ^ 8'h3c);
    acc(1'b1, 8'hed, 8'h03);
    acc(1'b1, 8'hea, 8'h21);
    rc(8'hea, 8'h20);
    rc(8'heb, 8'h07);
    for (k = 0; k < 3; k = k + 1) chk(i_udc_mem_model.sys_mem[260 + k], k ^ 8'h5a);
    // Bad launches: count above endpoint size, range past the window
    acc(1'b1, 8'hed, 8'h50);
    acc(1'b1, 8'hea, 8'h41);
    rc(8'hea, 8'h44);
    rc(8'heb, 8'h07);
    rc(8'hed, 8'h50);
    acc(1'b1, 8'hea, 8'h40);
    rc(8'hea, 8'h40);
    acc(1'b1, 8'heb, 8'hfe);
    acc(1'b1, 8'hec, 8'h08);
    acc(1'b1, 8'hed, 8'h04);
    acc(1'b1, 8'hea, 8'h13);
    rc(8'hea, 8'h16);
    rc(8'heb, 8'hfe);
    complete_run;
  end
endmodule // testbench
